// *** src/vsc_top.sv ***
// VBI insertion controls, copy-generation/wide-screen words and Y/U/V scaling.
// Assumes a host register port already decoded from the serial interface and
// timing strobes from the video timing generator, all on the pixel clock.
// Notes on behaviour
// - NTSC: a set per-line bit turns the pedestal off on that blanking line.
// - PAL: a set per-line bit turns teletext on for that blanking line.
// - Pedestal bits 0-15 map to lines 10-25, separate sets for fields 1/3 and 2/4.
// - Teletext bits 0-15 map to lines 7-22, separate sets per field pair.
// - Fall offset 0-15 clocks moves the request fall earlier, shortening the window.
// - With fall offset zero, the fall follows the rise so width stays constant.
// - Rise offset in the upper nibble moves the request rise by 0-15 clocks.
// - Control register low nibble gives the last four copy-generation bits while CRC select is clear.
// - CRC select set: six CRC bits computed internally; clear: register bits sent.
// - Odd-field enable inserts copy-generation data on odd fields, NTSC only.
// - Even-field enable inserts copy-generation data on even fields, NTSC only.
// - Control register top bit enables wide-screen output, PAL only.
// - Second register low six bits and third register are shared data bits.
// - Second register upper two bits are copy-generation data in every standard while CRC select is clear.
// - Luma is multiplied by contrast value over 128.
// - U is multiplied by U scale value over 128.
// - V is multiplied by V scale value over 128.
`timescale 1ns/1ns
module vsc_top
(
	// Clock and reset.
	input  wire logic               CLOCK_I,
	input  wire logic               RSTN_I,
	// Register port.
	input  wire logic               REG_WR_I,
	input  wire logic               REG_RD_I,
	input  wire logic [5:0]         REG_ADDR_I,
	input  wire logic [7:0]         REG_WDATA_I,
	output logic      [7:0]         REG_RDATA_O,
	// Video timing and pixels.
	input  wire vsc_pkg::vsc_timing_s TIMING_I,
	input  wire vsc_pkg::vsc_pixel_s  PIX_I,
	output vsc_pkg::vsc_pixel_s       PIX_O,
	// Blanking line controls.
	output logic                    PEDESTAL_OFF_O,
	output logic                    TELETEXT_LINE_O,
	output logic                    TELETEXT_REQUEST_OUT_O,
	// Copy-generation and wide-screen words.
	output logic      [19:0]        CGMS_WORD_O,
	output logic                    CGMS_INSERT_O,
	output logic      [13:0]        WSS_WORD_O,
	output logic                    WSS_ENABLE_O
);

	logic [15:0] odd_line_bits;
	logic [15:0] even_line_bits;
	logic [7:0]  copy_gen_ctrl_0;
	logic [7:0]  copy_gen_data_1;
	logic [7:0]  copy_gen_data_2;
	logic [7:0]  teletext_request_edges;
	logic [7:0]  luma_scale_value;
	logic [7:0]  u_scale_value;
	logic [7:0]  v_scale_value;
	logic [3:0]  fall_anchor;
	logic [15:0] act_odd_bits;
	logic [15:0] act_even_bits;
	logic [7:0]  act_ctrl;
	logic [7:0]  act_data_1;
	logic [7:0]  act_data_2;
	logic [3:0]  act_rise;
	logic [3:0]  act_fall;
	logic [3:0]  act_anchor;
	logic [7:0]  act_luma;
	logic [7:0]  act_u;
	logic [7:0]  act_v;
	logic [15:0] pix_count;
	logic [15:0] field_bits;
	logic [9:0]  ped_index;
	logic [9:0]  ttx_index;
	logic        ped_hit;
	logic        ttx_hit;
	logic [15:0] rise_pos;
	logic [15:0] fall_pos;
	logic [19:0] next_cgms_word;
	logic [7:0]  next_rdata;

	wire [3:0] fall_offset = teletext_request_edges[vsc_pkg::FALL_OFFSET_LSB +: 4];
	wire [3:0] rise_offset = teletext_request_edges[vsc_pkg::RISE_OFFSET_LSB +: 4];
	// Serial CRC over the fourteen leading data bits, bit 0 sent first.
	function automatic logic [5:0] crc6(input logic [13:0] data);
		logic [5:0] c;
		logic       fb;
		c = vsc_pkg::CRC_PRESET;
		for (int i = 0; i < 14; i++)
		begin
			fb = data[i] ^ c[5];
			c  = {c[4:1], c[0] ^ fb, fb};
		end
		return c;
	endfunction
	// Scale a signed sample by value/128 with saturation.
	function automatic logic [7:0] scale_s(input logic [7:0] pix, input logic [7:0] val);
		logic signed [16:0] p;
		logic signed [16:0] q;
		p = $signed(pix) * $signed({1'b0, val});
		q = p >>> vsc_pkg::SCALE_SHIFT;
		if (q > 17'sd127)
			return 8'h7f;
		else if (q < -17'sd128)
			return 8'h80;
		return q[7:0];
	endfunction
	// Scale an unsigned luma sample by value/128 with saturation.
	function automatic logic [7:0] scale_u(input logic [7:0] pix, input logic [7:0] val);
		logic [15:0] p;
		p = (pix * val) >> vsc_pkg::SCALE_SHIFT;
		return (p > 16'h00ff) ? 8'hff : p[7:0];
	endfunction
	// Host writes: every register keeps its last written value.
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			odd_line_bits          <= {2{vsc_pkg::RESET_BYTE}};
			even_line_bits         <= {2{vsc_pkg::RESET_BYTE}};
			copy_gen_ctrl_0        <= vsc_pkg::RESET_BYTE;
			copy_gen_data_1        <= vsc_pkg::RESET_BYTE;
			copy_gen_data_2        <= vsc_pkg::RESET_BYTE;
			teletext_request_edges <= vsc_pkg::RESET_BYTE;
			luma_scale_value       <= vsc_pkg::RESET_SCALE;
			u_scale_value          <= vsc_pkg::RESET_SCALE;
			v_scale_value          <= vsc_pkg::RESET_SCALE;
		end
		else if (REG_WR_I)
		begin
			case (REG_ADDR_I)
				vsc_pkg::ADDR_ODD_LINE_LOW:   odd_line_bits[7:0]     <= REG_WDATA_I;
				vsc_pkg::ADDR_ODD_LINE_HIGH:  odd_line_bits[15:8]    <= REG_WDATA_I;
				vsc_pkg::ADDR_EVEN_LINE_LOW:  even_line_bits[7:0]    <= REG_WDATA_I;
				vsc_pkg::ADDR_EVEN_LINE_HIGH: even_line_bits[15:8]   <= REG_WDATA_I;
				vsc_pkg::ADDR_COPY_GEN_CTRL:  copy_gen_ctrl_0        <= REG_WDATA_I;
				vsc_pkg::ADDR_COPY_GEN_1:     copy_gen_data_1        <= REG_WDATA_I;
				vsc_pkg::ADDR_COPY_GEN_2:     copy_gen_data_2        <= REG_WDATA_I;
				vsc_pkg::ADDR_TTX_EDGES:      teletext_request_edges <= REG_WDATA_I;
				vsc_pkg::ADDR_LUMA_SCALE:     luma_scale_value       <= REG_WDATA_I;
				vsc_pkg::ADDR_U_SCALE:        u_scale_value          <= REG_WDATA_I;
				vsc_pkg::ADDR_V_SCALE:        v_scale_value          <= REG_WDATA_I;
				default:                      ;
			endcase
		end
	end
	// Register read-back; unmapped subaddresses read as zero.
	always_comb
	begin
		case (REG_ADDR_I)
			vsc_pkg::ADDR_ODD_LINE_LOW:   next_rdata = odd_line_bits[7:0];
			vsc_pkg::ADDR_ODD_LINE_HIGH:  next_rdata = odd_line_bits[15:8];
			vsc_pkg::ADDR_EVEN_LINE_LOW:  next_rdata = even_line_bits[7:0];
			vsc_pkg::ADDR_EVEN_LINE_HIGH: next_rdata = even_line_bits[15:8];
			vsc_pkg::ADDR_COPY_GEN_CTRL:  next_rdata = copy_gen_ctrl_0;
			vsc_pkg::ADDR_COPY_GEN_1:     next_rdata = copy_gen_data_1;
			vsc_pkg::ADDR_COPY_GEN_2:     next_rdata = copy_gen_data_2;
			vsc_pkg::ADDR_TTX_EDGES:      next_rdata = teletext_request_edges;
			vsc_pkg::ADDR_LUMA_SCALE:     next_rdata = luma_scale_value;
			vsc_pkg::ADDR_U_SCALE:        next_rdata = u_scale_value;
			vsc_pkg::ADDR_V_SCALE:        next_rdata = v_scale_value;
			default:                      next_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			REG_RDATA_O <= 8'h00;
		else if (REG_RD_I)
			REG_RDATA_O <= next_rdata;
	end
	// The fall anchor follows the rise while the fall offset is zero, then freezes.
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			fall_anchor <= 4'h0;
		else if (fall_offset == 4'h0)
			fall_anchor <= rise_offset;
	end
	// Field-rate settings take effect at the next field start.
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			act_odd_bits  <= {2{vsc_pkg::RESET_BYTE}};
			act_even_bits <= {2{vsc_pkg::RESET_BYTE}};
			act_ctrl      <= vsc_pkg::RESET_BYTE;
			act_data_1    <= vsc_pkg::RESET_BYTE;
			act_data_2    <= vsc_pkg::RESET_BYTE;
		end
		else if (TIMING_I.field_start)
		begin
			act_odd_bits  <= odd_line_bits;
			act_even_bits <= even_line_bits;
			act_ctrl      <= copy_gen_ctrl_0;
			act_data_1    <= copy_gen_data_1;
			act_data_2    <= copy_gen_data_2;
		end
	end
	// Line-rate settings take effect at the next line start.
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			act_rise   <= 4'h0;
			act_fall   <= 4'h0;
			act_anchor <= 4'h0;
			act_luma   <= vsc_pkg::RESET_SCALE;
			act_u      <= vsc_pkg::RESET_SCALE;
			act_v      <= vsc_pkg::RESET_SCALE;
		end
		else if (TIMING_I.line_start)
		begin
			act_rise   <= rise_offset;
			act_fall   <= fall_offset;
			act_anchor <= fall_anchor;
			act_luma   <= luma_scale_value;
			act_u      <= u_scale_value;
			act_v      <= v_scale_value;
		end
	end
	// Pixel clock count since line start, saturating.
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			pix_count <= 16'h0000;
		else if (TIMING_I.line_start)
			pix_count <= 16'h0000;
		else if (pix_count != 16'hffff)
			pix_count <= pix_count + 16'h0001;
	end
	// Line selection within the blanking interval.
	always_comb
	begin
		field_bits = TIMING_I.odd_field ? act_odd_bits : act_even_bits;
		ped_index  = TIMING_I.line - vsc_pkg::PED_FIRST_LINE;
		ttx_index  = TIMING_I.line - vsc_pkg::TTX_FIRST_LINE;
		ped_hit    = (TIMING_I.line >= vsc_pkg::PED_FIRST_LINE) && (ped_index < 10'd16)
		             && field_bits[ped_index[3:0]];
		ttx_hit    = (TIMING_I.line >= vsc_pkg::TTX_FIRST_LINE) && (ttx_index < 10'd16)
		             && field_bits[ttx_index[3:0]];
		rise_pos   = vsc_pkg::TTX_RISE_BASE + {12'h000, act_rise};
		fall_pos   = vsc_pkg::TTX_RISE_BASE + vsc_pkg::TTX_WIDTH
		             + {12'h000, (act_fall == 4'h0) ? act_rise : act_anchor}
		             - {12'h000, act_fall};
	end
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			PEDESTAL_OFF_O         <= 1'b0;
			TELETEXT_LINE_O        <= 1'b0;
			TELETEXT_REQUEST_OUT_O <= 1'b0;
		end
		else
		begin
			PEDESTAL_OFF_O         <= !TIMING_I.pal && ped_hit;
			TELETEXT_LINE_O        <= TIMING_I.pal && ttx_hit;
			TELETEXT_REQUEST_OUT_O <= TIMING_I.pal && ttx_hit && !TIMING_I.line_start
			                          && (pix_count >= rise_pos) && (pix_count < fall_pos);
		end
	end
	// Copy-generation word, bit 0 sent first: data 2, data 1, control low nibble.
	always_comb
	begin
		next_cgms_word = {act_ctrl[3:0], act_data_1, act_data_2};
		if (act_ctrl[vsc_pkg::CRC_INTERNAL_BIT])
			next_cgms_word[19:14] = crc6(next_cgms_word[13:0]);
	end
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			CGMS_WORD_O   <= 20'h0_0000;
			CGMS_INSERT_O <= 1'b0;
			WSS_WORD_O    <= 14'h0000;
			WSS_ENABLE_O  <= 1'b0;
		end
		else
		begin
			CGMS_WORD_O   <= next_cgms_word;
			CGMS_INSERT_O <= !TIMING_I.pal && (TIMING_I.odd_field
			                 ? act_ctrl[vsc_pkg::ODD_ENABLE_BIT]
			                 : act_ctrl[vsc_pkg::EVEN_ENABLE_BIT]);
			WSS_WORD_O    <= {act_data_1[5:0], act_data_2};
			WSS_ENABLE_O  <= TIMING_I.pal && act_ctrl[vsc_pkg::WS_ENABLE_BIT];
		end
	end
	// Pixel scaling; U and V are two's complement, luma is unsigned.
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			PIX_O <= '0;
		else
		begin
			PIX_O.y <= scale_u(PIX_I.y, act_luma);
			PIX_O.u <= scale_s(PIX_I.u, act_u);
			PIX_O.v <= scale_s(PIX_I.v, act_v);
		end
	end
	a_pedestal_line: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		(!TIMING_I.pal && TIMING_I.odd_field && TIMING_I.line == 10'd10 && act_odd_bits[0]
		 && !TIMING_I.field_start) |=> PEDESTAL_OFF_O)
		else $error("Pedestal not removed on selected NTSC line");
	a_teletext_line: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		(TIMING_I.pal && TIMING_I.odd_field && TIMING_I.line == 10'd22 && act_odd_bits[15]
		 && !TIMING_I.field_start) |=> TELETEXT_LINE_O)
		else $error("Teletext not enabled on selected PAL line");
	a_ped_window: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		(TIMING_I.line > 10'd25 || TIMING_I.line < 10'd10) |=> !PEDESTAL_OFF_O)
		else $error("Pedestal removed outside lines 10 to 25");
	a_request_rise: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		$rose(TELETEXT_REQUEST_OUT_O) |-> $past(pix_count) == rise_pos)
		else $error("Teletext request rose at wrong clock");
	a_request_fall: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		($fell(TELETEXT_REQUEST_OUT_O) && !$past(TIMING_I.line_start))
		|-> $past(pix_count) == fall_pos)
		else $error("Teletext request fell at wrong clock");
	a_fall_tracks: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		(act_fall == 4'h0) |-> (fall_pos - rise_pos) == vsc_pkg::TTX_WIDTH)
		else $error("Request width changed with zero fall offset");
	a_cgms_tail: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		!act_ctrl[vsc_pkg::CRC_INTERNAL_BIT] |=> CGMS_WORD_O[19:16] == $past(act_ctrl[3:0]))
		else $error("Copy-generation tail bits differ from control nibble");
	a_cgms_odd: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		(TIMING_I.pal || (TIMING_I.odd_field && !act_ctrl[vsc_pkg::ODD_ENABLE_BIT]))
		|=> !CGMS_INSERT_O)
		else $error("Copy-generation inserted while disabled");
	a_wss_pal: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		WSS_ENABLE_O |-> $past(TIMING_I.pal) && $past(act_ctrl[vsc_pkg::WS_ENABLE_BIT]))
		else $error("Wide-screen output outside PAL or while disabled");
	a_luma_unity: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
		(RSTN_I && act_luma == 8'h80) |=> PIX_O.y == $past(PIX_I.y))
		else $error("Luma changed at unity contrast");
endmodule

// *** pkg/vsc_pkg.sv ***
// Package for the VBI insertion and scale control block.
// Assumes a single 27 MHz pixel clock domain and six-bit register subaddresses.
package vsc_pkg;

	// Register subaddresses.
	localparam logic [5:0] ADDR_ODD_LINE_LOW   = 6'h15;
	localparam logic [5:0] ADDR_ODD_LINE_HIGH  = 6'h16;
	localparam logic [5:0] ADDR_EVEN_LINE_LOW  = 6'h17;
	localparam logic [5:0] ADDR_EVEN_LINE_HIGH = 6'h18;
	localparam logic [5:0] ADDR_COPY_GEN_CTRL  = 6'h19;
	localparam logic [5:0] ADDR_COPY_GEN_1     = 6'h1a;
	localparam logic [5:0] ADDR_COPY_GEN_2     = 6'h1b;
	localparam logic [5:0] ADDR_TTX_EDGES      = 6'h1c;
	localparam logic [5:0] ADDR_LUMA_SCALE     = 6'h1d;
	localparam logic [5:0] ADDR_U_SCALE        = 6'h1e;
	localparam logic [5:0] ADDR_V_SCALE        = 6'h1f;

	// Field positions inside the control and edge registers.
	localparam int CRC_INTERNAL_BIT = 4;
	localparam int ODD_ENABLE_BIT   = 5;
	localparam int EVEN_ENABLE_BIT  = 6;
	localparam int WS_ENABLE_BIT    = 7;
	localparam int FALL_OFFSET_LSB  = 0;
	localparam int RISE_OFFSET_LSB  = 4;

	// Reset values.
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [7:0] RESET_SCALE = 8'h80;

	// Vertical blanking line windows.
	localparam logic [9:0] PED_FIRST_LINE = 10'h00a;
	localparam logic [9:0] TTX_FIRST_LINE = 10'h007;

	// Teletext request timing in pixel clocks.
	localparam logic [15:0] TTX_RISE_BASE = 16'h0040;
	localparam logic [15:0] TTX_WIDTH     = 16'h0168;

	// Scale shift: factor is value divided by 128.
	localparam int SCALE_SHIFT = 7;

	// Copy-generation CRC: x^6 + x + 1, preset to all ones.
	localparam logic [5:0] CRC_PRESET = 6'h3f;

	typedef struct packed {
		logic       pal;
		logic       odd_field;
		logic       field_start;
		logic       line_start;
		logic [9:0] line;
	} vsc_timing_s;

	typedef struct packed {
		logic [7:0] y;
		logic [7:0] u;
		logic [7:0] v;
	} vsc_pixel_s;

endpackage

// *** dv/vsc_vid_src.sv ***
// Model of the video timing source and the teletext data source.
// Assumes the bench picks the standard; each request pulse is measured.
`timescale 1ns/1ns
module vsc_vid_src
#(
	parameter int LINE_LEN = 450,
	parameter int LINES    = 26
)
(
	// Clock and reset.
	input  wire logic           clock_i,
	input  wire logic           rstn_i,
	// Standard and request.
	input  wire logic           pal_i,
	input  wire logic           req_i,
	// Timing and measurements.
	output vsc_pkg::vsc_timing_s timing_o,
	output logic [15:0]         rise_at_o,
	output logic [15:0]         width_o
);
	logic [15:0] pos;
	logic [9:0]  line;
	logic        odd;
	logic        req_d;
	logic [15:0] high_cnt;

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pos  <= 16'h0000;
			line <= 10'h000;
			odd  <= 1'b1;
		end
		else
		begin
			pos <= (pos == 16'(LINE_LEN - 1)) ? 16'h0000 : pos + 16'h0001;
			if (pos == 16'(LINE_LEN - 1))
			begin
				line <= (line == 10'(LINES - 1)) ? 10'h000 : line + 10'h001;
				odd  <= (line == 10'(LINES - 1)) ? !odd : odd;
			end
		end
	end

	// The source times its data from the request, so it records where it rises and how long.
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			req_d     <= 1'b0;
			high_cnt  <= 16'h0000;
			rise_at_o <= 16'h0000;
			width_o   <= 16'h0000;
		end
		else
		begin
			req_d <= req_i;
			if (req_i && !req_d)
			begin
				rise_at_o <= pos;
				high_cnt  <= 16'h0001;
			end
			else if (req_i)
				high_cnt <= high_cnt + 16'h0001;
			if (!req_i && req_d)
				width_o <= high_cnt;
		end
	end

	assign timing_o = '{pal_i, odd, pos == 16'h0000 && line == 10'h000, pos == 16'h0000, line};
endmodule

// *** dv/vsc_top_tb.sv ***
// Self-checking bench for the blanking, copy-generation and scale controls.
// Assumes the timing source model drives the video timing inputs.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end
module vsc_top_tb;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic [7:0] rst;
		logic [7:0] back;
	} vsc_row_s;
	localparam int CYCLE_LIMIT = 95000;
	logic                 clk = 1'b0;
	logic                 rstn = 1'b0;
	logic                 reg_wr = 1'b0;
	logic                 reg_rd = 1'b0;
	logic [5:0]           reg_addr = 6'h00;
	logic [7:0]           reg_wdata = 8'h00;
	logic [7:0]           reg_rdata;
	logic                 pal = 1'b0;
	vsc_pkg::vsc_timing_s timing;
	vsc_pkg::vsc_pixel_s  pix_in = '{8'hc8, 8'h9c, 8'h33};
	vsc_pkg::vsc_pixel_s  pix_out;
	logic                 ped_off, ttx_line, ttx_req, cg_ins, ws_en;
	logic [19:0]          cg_word;
	logic [13:0]          ws_word;
	logic [15:0]          rise_at, width, base_r, base_w;
	logic [7:0]           d;
	int                   fails = 0;
	int                   tests_run = 0;
	int                   cycles = 0;
	// Scale rows: 1.5 x 128 = 192, 0.5 x 128 = 64, 1.18 x 128 = 151.
	vsc_row_s rows [12] = '{
		'{6'h15, 8'h01, 8'h00, 8'h01}, '{6'h16, 8'h80, 8'h00, 8'h80},
		'{6'h17, 8'h02, 8'h00, 8'h02}, '{6'h18, 8'h00, 8'h00, 8'h00},
		'{6'h19, 8'h65, 8'h00, 8'h65}, '{6'h1a, 8'hc3, 8'h00, 8'hc3},
		'{6'h1b, 8'h5a, 8'h00, 8'h5a}, '{6'h1c, 8'h30, 8'h00, 8'h30},
		'{6'h1d, 8'hc0, 8'h80, 8'hc0}, '{6'h1e, 8'h40, 8'h80, 8'h40},
		'{6'h1f, 8'h97, 8'h80, 8'h97}, '{6'h20, 8'hff, 8'h00, 8'h00}};
	logic [7:0]  edge_v [4] = '{8'h00, 8'h90, 8'h95, 8'h9f};
	logic [15:0] d_r [4] = '{16'h0000, 16'h0009, 16'h0009, 16'h0009};
	logic [15:0] d_w [4] = '{16'h0000, 16'h0000, 16'h0005, 16'h000f};

	vsc_top dut (.CLOCK_I(clk), .RSTN_I(rstn), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
		.REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
		.TIMING_I(timing), .PIX_I(pix_in), .PIX_O(pix_out), .PEDESTAL_OFF_O(ped_off),
		.TELETEXT_LINE_O(ttx_line), .TELETEXT_REQUEST_OUT_O(ttx_req),
		.CGMS_WORD_O(cg_word), .CGMS_INSERT_O(cg_ins), .WSS_WORD_O(ws_word),
		.WSS_ENABLE_O(ws_en));
	vsc_vid_src src (.clock_i(clk), .rstn_i(rstn), .pal_i(pal), .req_i(ttx_req),
		.timing_o(timing), .rise_at_o(rise_at), .width_o(width));

	always #5 clk = ~clk;

	task automatic report_and_stop;
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == CYCLE_LIMIT)
		begin
			fails++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask

	task automatic wait_ln(input logic [9:0] n);
		do @(posedge clk); while (!(timing.line_start && timing.line == n));
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic wait_fl(input logic o, input logic [9:0] n);
		do @(posedge clk); while (!(timing.field_start && timing.odd_field == o));
		wait_ln(n);
	endtask

	// Copy-generation word with the optional CRC over its first fourteen bits.
	function automatic logic [19:0] cgw(input logic [7:0] c, d1, d2);
		logic [19:0] w;
		logic [5:0]  r;
		logic        fb;
		w = {c[3:0], d1, d2};
		r = 6'h3f;
		for (int i = 0; i < 14; i++)
		begin
			fb = w[i] ^ r[5];
			r = {r[4:1], r[0] ^ fb, fb};
		end
		if (c[4])
			w[19:14] = r;
		return w;
	endfunction

	initial
	begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i])
		begin
			rd(rows[i].addr);
			`CHK("reset value", rows[i].rst, d);
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr);
			`CHK("read back", rows[i].back, d);
		end
		wait_fl(1'b1, 10'd10);
		`CHK("pedestal off", 1'b1, ped_off);
		`CHK("teletext line", 1'b0, ttx_line);
		`CHK("copy insert", 1'b1, cg_ins);
		`CHK("copy word", cgw(8'h65, 8'hc3, 8'h5a), cg_word);
		`CHK("wide enable", 1'b0, ws_en);
		`CHK("pixel", 24'hff_ce3c, pix_out);
		wait_ln(10'd11);
		`CHK("pedestal off", 1'b0, ped_off);
		wait_ln(10'd25);
		`CHK("pedestal off", 1'b1, ped_off);
		wait_fl(1'b0, 10'd10);
		`CHK("pedestal off", 1'b0, ped_off);
		wait_ln(10'd11);
		`CHK("pedestal off", 1'b1, ped_off);
		`CHK("copy insert", 1'b1, cg_ins);
		pal <= 1'b1;
		for (int a = 21; a < 25; a++)
			wr(6'(a), 8'hff);
		wr(vsc_pkg::ADDR_COPY_GEN_CTRL, 8'h95);
		wait_fl(1'b1, 10'd7);
		`CHK("teletext line", 1'b1, ttx_line);
		`CHK("pedestal off", 1'b0, ped_off);
		`CHK("wide enable", 1'b1, ws_en);
		`CHK("wide word", {6'h03, 8'h5a}, ws_word);
		`CHK("copy insert", 1'b0, cg_ins);
		wait_ln(10'd23);
		`CHK("teletext line", 1'b0, ttx_line);
		wait_ln(10'd8);
		for (int i = 0; i < 4; i++)
		begin
			wr(vsc_pkg::ADDR_TTX_EDGES, edge_v[i]);
			wait_ln(10'(11 + 3 * i));
			if (i == 0)
			begin
				base_r = rise_at;
				base_w = width;
			end
			else
			begin
				`CHK("request rise", base_r + d_r[i], rise_at);
				`CHK("request width", base_w - d_w[i], width);
			end
		end
		pal <= 1'b0;
		wr(vsc_pkg::ADDR_COPY_GEN_CTRL, 8'h55);
		wait_fl(1'b1, 10'd10);
		`CHK("copy insert", 1'b0, cg_ins);
		`CHK("copy word", cgw(8'h55, 8'hc3, 8'h5a), cg_word);
		wait_fl(1'b0, 10'd10);
		`CHK("copy insert", 1'b1, cg_ins);
		// A reset in mid-run must drop the copy insert output and restore the luma scale and control register defaults.
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("reset insert", 1'b0, cg_ins);
		@(posedge clk);
		rstn <= 1'b1;
		rd(vsc_pkg::ADDR_LUMA_SCALE);
		`CHK("reset value", vsc_pkg::RESET_SCALE, d);
		rd(vsc_pkg::ADDR_COPY_GEN_CTRL);
		`CHK("reset value", vsc_pkg::RESET_BYTE, d);
		report_and_stop();
	end
endmodule
